/* rtl/sar_conversion_sequencer.sv */
// Function
// R01: In periods one to three every weighting element sits on the input and the comparator auto-balances.
// R02: In period four the input is released, the top element goes to the positive reference, the rest negative.
// R03: At the end of period four the comparator decision becomes the top bit and decides where its element stays.
// R04: At the end of periods five to fourteen one bit, ten down to one, is trialled, stored and settled.
// R05: At the end of period fifteen bit zero is trialled and the whole word moves into the output registers.
// R06: The period-fifteen transfer raises the data-ready flag.
// R07: After the final transfer all elements return to the input and the comparator to balance.
// R08: Track/hold is in hold from period four through fifteen and tracks from period one.
// R09: With no external clock fitted the block runs from an internal oscillator, 200 kHz least, 300 kHz typical.
// R10: An external clock must stay within 0.05 to 2 MHz.
// R11: The output registers keep the previous result until the next period-fifteen transfer.
// R12: The comparator decision is one input bit sampled at the end of each trial period four to fifteen.
// R13: The active-low start is honoured only after period fifteen; held low the block free-runs.
// R14: Data-ready rises at the start of period one and falls at the start of period two.
// R15: The active-low upper enable drives bits four to eleven, the lower enable bits zero to three, else high-impedance.
// R16: A conversion lasts exactly fifteen periods, all actions on the rising conversion clock.
`timescale 1ns/100ps
`include "sar_seq_regs.svh"

module sar_conversion_sequencer
	import sar_seq_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        reset_i,
	input  wire logic        ext_clk_present_i,
	input  wire logic        ext_clk_i,
	input  wire logic        comp_i,
	input  wire logic        convert_request_n_i,
	input  wire logic        upper_group_output_enable_n_i,
	input  wire logic        lower_group_output_enable_n_i,
	output logic             conv_clk_o,
	output logic             track_o,
	output logic             input_connect_o,
	output logic             comp_balance_o,
	output logic [11:0]      ref_pos_o,
	output result_bus_s      result_o,
	output logic             result_valid_flag_o
);
	seq_state_e  state_q;
	seq_state_e  state_d;
	logic [3:0]  period_q;
	logic [3:0]  period_d;
	logic [11:0] ref_pos_q;
	logic [11:0] ref_pos_d;
	logic [11:0] result_q;
	logic [11:0] oe_q;
	logic        track_q;
	logic        ready_q;
	logic        tick;

	sar_conv_clock u_clock (
		.mclk_i            (mclk_i),
		.reset_i           (reset_i),
		.ext_clk_present_i (ext_clk_present_i),
		.ext_clk_i         (ext_clk_i),
		.tick_o            (tick),
		.conv_clk_o        (conv_clk_o)
	);

	wire        running   = (state_q == ST_RUN);
	wire        end_track = running && (period_q == `SAR_PER_LAST_TRK);
	wire        end_trial = running && (period_q >= `SAR_PER_MSB);
	wire        end_last  = running && (period_q == `SAR_PER_LAST);
	wire [3:0]  bit_idx   = `SAR_PER_LAST - period_q;
	wire        start_ok  = !convert_request_n_i && (end_last || !running);
	wire [11:0] final_word = {ref_pos_q[11:1], comp_i};
	wire [11:0] oe_d      = {{`SAR_UPPER_W{~upper_group_output_enable_n_i}},
	                         {`SAR_LOWER_W{~lower_group_output_enable_n_i}}};

	// Start only sampled once the last period has closed, or while idle [R13]
	assign state_d  = start_ok ? ST_RUN : (end_last ? ST_IDLE : state_q);
	assign period_d = start_ok ? `SAR_PER_FIRST : (running ? period_q + 4'h1 : period_q); // [R16]

	// Successive approximation: keep the decided bit, trial the next one down
	always_comb begin
		ref_pos_d = ref_pos_q;
		if (end_track) begin
			ref_pos_d = `SAR_MSB_TRIAL; // [R02]
		end else if (end_last) begin
			ref_pos_d = `SAR_RES_RESET; // [R07]
		end else if (end_trial) begin
			ref_pos_d[bit_idx]        = comp_i; // [R03] [R04] [R12]
			ref_pos_d[bit_idx - 4'h1] = 1'b1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			state_q   <= ST_IDLE;
			period_q  <= `SAR_PER_FIRST;
			ref_pos_q <= `SAR_RES_RESET;
			track_q   <= 1'b1;
		end else if (tick) begin
			state_q   <= state_d;
			period_q  <= period_d;
			ref_pos_q <= ref_pos_d;
			if (end_track) begin
				track_q <= 1'b0; // [R08]
			end else if (end_last) begin
				track_q <= 1'b1; // [R01] [R07] [R08]
			end
		end
	end

	// Output word only moves on the period-fifteen transfer
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			result_q <= `SAR_RES_RESET;
			ready_q  <= 1'b0;
		end else if (tick) begin
			if (end_last) begin
				result_q <= final_word; // [R05] [R11]
				ready_q  <= 1'b1; // [R06] [R14]
			end else if (running && period_q == `SAR_PER_FIRST) begin
				ready_q  <= 1'b0; // [R14]
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			oe_q <= 12'h000;
		end else begin
			oe_q <= oe_d; // [R15]
		end
	end

	assign track_o             = track_q;
	assign input_connect_o     = track_q;
	assign comp_balance_o      = track_q;
	assign ref_pos_o           = ref_pos_q;
	assign result_o            = {result_q, oe_q};
	assign result_valid_flag_o = ready_q;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);

	property p_track_early;
		running && period_q <= `SAR_PER_LAST_TRK |-> input_connect_o && comp_balance_o;
	endproperty
	a_track_early: assert property (p_track_early) else $error("elements off input in tracking"); // [R01]

	property p_msb_trial;
		tick && end_track |=> ref_pos_o == 12'h800 && !input_connect_o;
	endproperty
	a_msb_trial: assert property (p_msb_trial) else $error("top bit trial not set up"); // [R02]

	property p_msb_store;
		tick && running && period_q == 4'h4 |=> ref_pos_o[11] == $past(comp_i) && ref_pos_o[10];
	endproperty
	a_msb_store: assert property (p_msb_store) else $error("top bit not stored"); // [R03]

	property p_bit_store;
		tick && running && period_q >= 4'h5 && period_q <= 4'he |=> ref_pos_o[$past(bit_idx)] == $past(comp_i);
	endproperty
	a_bit_store: assert property (p_bit_store) else $error("trial bit not stored"); // [R04]

	property p_transfer;
		tick && end_last |=> result_o.data == {$past(ref_pos_q[11:1]), $past(comp_i)} && result_valid_flag_o;
	endproperty
	a_transfer: assert property (p_transfer) else $error("final transfer wrong"); // [R05]

	property p_ready_set;
		$rose(result_valid_flag_o) |-> $past(tick && end_last);
	endproperty
	a_ready_set: assert property (p_ready_set) else $error("ready rose without transfer"); // [R06]

	property p_back_to_track;
		tick && end_last |=> input_connect_o && comp_balance_o && ref_pos_o == 12'h000;
	endproperty
	a_back_to_track: assert property (p_back_to_track) else $error("not returned to tracking"); // [R07]

	property p_hold;
		running && period_q >= `SAR_PER_MSB |-> !track_o;
	endproperty
	a_hold: assert property (p_hold) else $error("tracking during hold periods"); // [R08]

	property p_keep_result;
		!(tick && end_last) |=> $stable(result_o.data);
	endproperty
	a_keep_result: assert property (p_keep_result) else $error("result changed mid conversion"); // [R11]

	property p_free_run;
		tick && end_last && !convert_request_n_i |=> running && period_q == 4'h1;
	endproperty
	a_free_run: assert property (p_free_run) else $error("restart missed"); // [R13]

	property p_ready_fall;
		tick && running && period_q == 4'h1 |=> !result_valid_flag_o;
	endproperty
	a_ready_fall: assert property (p_ready_fall) else $error("ready not cleared in period two"); // [R14]

	property p_enables;
		##1 result_o.oe == {{8{!$past(upper_group_output_enable_n_i)}}, {4{!$past(lower_group_output_enable_n_i)}}};
	endproperty
	a_enables: assert property (p_enables) else $error("output enable group wrong"); // [R15]

	property p_period_step;
		tick && running && period_q < 4'hf && !start_ok |=> period_q == $past(period_q) + 4'h1 && running;
	endproperty
	a_period_step: assert property (p_period_step) else $error("period count skipped"); // [R16]

	c_transfer: cover property (tick && end_last);
	c_free_run: cover property (tick && end_last && !convert_request_n_i);
	c_idle_start: cover property (tick && !running && !convert_request_n_i);
	c_one_result: cover property (tick && end_last && comp_i);
endmodule

/* shared/sar_seq_regs.svh */
`ifndef SAR_SEQ_REGS_SVH
`define SAR_SEQ_REGS_SVH

// Result word and enable groups
`define SAR_RES_W        12
`define SAR_UPPER_LSB    4
`define SAR_UPPER_W      8
`define SAR_LOWER_W      4
`define SAR_MSB_TRIAL    12'h800
`define SAR_RES_RESET    12'h000

// Conversion period numbering
`define SAR_PER_FIRST    4'h1
`define SAR_PER_LAST_TRK 4'h3
`define SAR_PER_MSB      4'h4
`define SAR_PER_LAST     4'hf

// Clock figures in kHz
`define SAR_MCLK_KHZ     40000
`define SAR_INT_MIN_KHZ  200
`define SAR_INT_TYP_KHZ  300
`define SAR_EXT_MIN_KHZ  50
`define SAR_EXT_MAX_KHZ  2000
// Typical internal period rounds down to whole master cycles
`define SAR_INT_DIV      (`SAR_MCLK_KHZ / `SAR_INT_TYP_KHZ)

`endif

/* shared/sar_seq_pkg.sv */
package sar_seq_pkg;
	typedef enum logic {
		ST_IDLE,
		ST_RUN
	} seq_state_e;

	typedef struct packed {
		logic [11:0] data;
		logic [11:0] oe;
	} result_bus_s;
endpackage

/* rtl/sar_conv_clock.sv */
`timescale 1ns/100ps
`include "sar_seq_regs.svh"

module sar_conv_clock
	import sar_seq_pkg::*;
(
	input  wire logic mclk_i,
	input  wire logic reset_i,
	input  wire logic ext_clk_present_i,
	input  wire logic ext_clk_i,
	output logic      tick_o,
	output logic      conv_clk_o
);
	localparam logic [7:0] DIV_LAST = 8'(`SAR_INT_DIV - 1);
	localparam logic [7:0] DIV_HALF = 8'(`SAR_INT_DIV / 2);

	logic [7:0] div_q;
	logic       ext_q;
	wire        div_wrap = (div_q == DIV_LAST);
	wire        ext_rise = ext_clk_i & ~ext_q;
	wire        tick_d   = ext_clk_present_i ? ext_rise : div_wrap;
	wire        clk_d    = ext_clk_present_i ? ext_clk_i : (div_q < DIV_HALF);

	// Internal oscillator is a divider running whenever no external clock is fitted [R09]
	always_ff @(posedge mclk_i) begin
		if (reset_i || div_wrap || ext_clk_present_i) begin
			div_q <= 8'h00;
		end else begin
			div_q <= div_q + 8'h01;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			// Follow the pin through reset so a clock parked high gives no false first edge
			ext_q      <= ext_clk_i;
			tick_o     <= 1'b0;
			conv_clk_o <= 1'b0;
		end else begin
			ext_q      <= ext_clk_i;
			tick_o     <= tick_d;
			conv_clk_o <= clk_d;
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);

	property p_int_rate;
		!ext_clk_present_i && div_wrap |-> ##(`SAR_INT_DIV) div_wrap;
	endproperty
	a_int_rate: assert property (p_int_rate) else $error("internal period tick rate wrong"); // [R09]
endmodule

/* bench/host_reader.sv */
`timescale 1ns/100ps

module host_reader
	import sar_seq_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire result_bus_s res_i,
	output logic             start_n_o,
	output logic             upper_n_o,
	output logic             lower_n_o
);
	logic [11:0] bus_w;

	initial begin
		start_n_o = 1'b1;
		upper_n_o = 1'b1;
		lower_n_o = 1'b1;
	end

	// Bits whose driver is off float on the shared bus
	for (genvar i = 0; i < 12; i++) begin : g_bus
		assign bus_w[i] = res_i.oe[i] ? res_i.data[i] : 1'bz;
	end

	task automatic go(input logic v);
		@(negedge mclk_i);
		start_n_o = v;
	endtask

	task automatic read(input logic up, input logic lo, output logic [11:0] w);
		@(negedge mclk_i);
		upper_n_o = ~up;
		lower_n_o = ~lo;
		repeat (2) @(negedge mclk_i);
		w = bus_w;
		upper_n_o = 1'b1;
		lower_n_o = 1'b1;
	endtask
endmodule

/* bench/sar_conversion_sequencer_tb.sv */
`timescale 1ns/100ps
`include "sar_seq_regs.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end

module sar_conversion_sequencer_tb;
	import sar_seq_pkg::*;
	localparam int DIV = `SAR_INT_DIV;
	logic        mclk = 1'b0;
	logic        reset = 1'b1;
	logic        ext_present;
	logic        ext_run = 1'b0;
	logic        ext_clk = 1'b0;
	logic        comp;
	logic [11:0] target = 12'h000;
	logic        start_n, upper_n, lower_n;
	logic        conv_clk, track, input_connect, comp_balance, flag;
	logic [11:0] ref_pos;
	result_bus_s result;
	int          fails = 0;
	int          checked = 0;

	always #12.5 mclk = ~mclk;
	// External conversion clock of 1 MHz, 40 master cycles a period
	always #500 if (ext_run) ext_clk = ~ext_clk;
	// Ideal comparator: input at or above the current trial word
	always @(negedge mclk) comp <= (target >= ref_pos);

	sar_conversion_sequencer DUT (.mclk_i(mclk), .reset_i(reset), .ext_clk_present_i(ext_present),
		.ext_clk_i(ext_clk), .comp_i(comp), .convert_request_n_i(start_n),
		.upper_group_output_enable_n_i(upper_n), .lower_group_output_enable_n_i(lower_n),
		.conv_clk_o(conv_clk), .track_o(track), .input_connect_o(input_connect),
		.comp_balance_o(comp_balance), .ref_pos_o(ref_pos), .result_o(result),
		.result_valid_flag_o(flag));

	host_reader host (.mclk_i(mclk), .res_i(result), .start_n_o(start_n), .upper_n_o(upper_n),
		.lower_n_o(lower_n));

	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic wait_for(input logic trk, input logic lvl, output int n);
		n = 0;
		while ((trk ? track : flag) !== lvl) begin
			@(negedge mclk);
			n++;
			if (n > 2500) begin
				fails++;
				$display("[FAIL] t=%0t got=%h exp=%h", $time, ~lvl, lvl);
				summarize();
			end
		end
	endtask

	task automatic do_reset();
		reset = 1'b1;
		repeat (5) @(negedge mclk);
		reset = 1'b0;
	endtask

	task automatic t_single();
		int n;
		target = 12'ha5c;
		host.go(1'b0);
		wait_for(1'b1, 1'b0, n);
		`CHK(ref_pos, `SAR_MSB_TRIAL)
		`CHK({input_connect, comp_balance}, 2'b00)
		host.go(1'b1);
		wait_for(1'b0, 1'b1, n);
		`CHK(result.data, 12'ha5c)
		`CHK({track, input_connect, comp_balance}, 3'b111)
		`CHK(conv_clk, 1'b1)
		repeat (3 * DIV + DIV / 2 + 4) @(negedge mclk);
		`CHK({flag, track}, 2'b11)
		`CHK(conv_clk, 1'b0)
		$display("test single done");
	endtask

	task automatic t_enables();
		logic [11:0] w;
		logic [11:0] e;
		for (int k = 0; k < 4; k++) begin
			host.read(k[1], k[0], w);
			e = {k[1] ? 8'ha5 : 8'hzz, k[0] ? 4'hc : 4'hz};
			`CHK(w, e)
		end
		$display("test enables done");
	endtask

	task automatic t_free();
		int n;
		int m;
		target = 12'h3c1;
		host.go(1'b0);
		wait_for(1'b0, 1'b0, n);
		wait_for(1'b1, 1'b0, n);
		`CHK(result.data, 12'ha5c)
		wait_for(1'b0, 1'b1, n);
		`CHK(n, 12 * DIV)
		`CHK(result.data, 12'h3c1)
		target = 12'h000;
		wait_for(1'b0, 1'b0, n);
		`CHK(n, DIV)
		wait_for(1'b0, 1'b1, m);
		`CHK(n + m, 15 * DIV)
		`CHK(result.data, 12'h000)
		host.go(1'b1);
		$display("test free run done");
	endtask

	task automatic t_ext();
		int n;
		`CHK({flag, track, result.data}, 14'h1000)
		target = 12'hfff;
		host.go(1'b0);
		wait_for(1'b0, 1'b1, n);
		`CHK(result.data, 12'hfff)
		`CHK(conv_clk, 1'b1)
		target = 12'h001;
		wait_for(1'b0, 1'b0, n);
		wait_for(1'b0, 1'b1, n);
		`CHK(n, 14 * 40)
		`CHK(result.data, 12'h001)
		host.go(1'b1);
		$display("test external clock done");
	endtask

	initial begin
		ext_present = 1'b0;
		do_reset();
		t_single();
		t_enables();
		t_free();
		ext_present = 1'b1;
		ext_run = 1'b1;
		do_reset();
		t_ext();
		summarize();
	end
endmodule
